// ---- design/sfr_status.sv ----
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`include "sfr_defines.svh"

// How it works
// - Bit 5 selects bank 1 or bank 0 and forms the top bit of a direct data address.
// - Bit 4 goes to one on power-up, a watchdog kick or sleep, and to zero on a time-out.
// - Bit 3 goes to one on power-up or a watchdog kick, and to zero on sleep.
// - Bit 2 is one when an arithmetic or logic result is zero and zero otherwise.
// - For add and subtract bit 1 holds the carry out of the low nibble.
// - For add and subtract bit 0 holds the carry out of the top result bit.
// - Subtract adds the two's complement, so both carries read one when no borrow.
// - Rotates load bit 0 with the bit shifted out of the source.
// - Reset clears bit 5 and sets bits 4 and 3; those two are read-only.
// - A flag-changing instruction aimed at this register keeps its flags in bits 2 to 0; bits 7 to 5 take the data, bits 7 and 6 only with the guard off.
// - Instruction writes never change bits 4 and 3.
module sfr_status
(
	// clock and reset
	input  wire logic                clk_sys_in,
	input  wire logic                srst_in,
	// instruction commit
	input  wire logic                exec_in,
	input  wire sfr_pkg::sfr_op_type op_in,
	input  wire logic [7:0]          w_in,
	input  wire logic [7:0]          f_in,
	input  wire logic                dest_status_in,
	// watchdog and power events
	input  wire logic                wdog_kick_in,
	input  wire logic                sleep_in,
	input  wire logic                wdog_expire_in,
	// direct addressing
	input  wire logic [6:0]          dir_addr_in,
	output logic [7:0]               bank_addr_out,
	output logic                     bank_sel_out,
	// result and status
	output logic [7:0]               result_out,
	output logic [7:0]               status_out,
	// ahb-lite slave
	input  wire logic                hsel_in,
	input  wire logic [31:0]         haddr_in,
	input  wire logic [1:0]          htrans_in,
	input  wire logic                hwrite_in,
	input  wire logic [2:0]          hsize_in,
	input  wire logic [31:0]         hwdata_in,
	input  wire logic                hready_in,
	output logic                     hreadyout_out,
	output logic [31:0]              hrdata_out,
	output logic                     hresp_out,
	// interrupt
	output logic                     irq_out
);
	import sfr_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] status_r;
	logic [7:0] result_r;
	logic [7:0] bank_addr_r;
	logic [7:0] alu_res;
	logic       alu_zero;
	logic       alu_nib;
	logic       alu_msb;
	logic       upd_zero;
	logic       upd_nib;
	logic       upd_msb;
	logic       data_wr;
	logic       flag_blk;
	logic [1:0] rsvd_nxt;
	logic [3:0] ev;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic       ctrl_guard_r;
	logic       irq_r;
	logic       ap_take;
	logic       dp_wr_r;
	logic [7:0] dp_addr_r;
	logic [31:0] hrdata_r;

	// ****************************************
	// alu
	// ****************************************
	sfr_alu sfr_alu_inst
	(
		.op_in        (op_in),
		.w_in         (w_in),
		.f_in         (f_in),
		.carry_in     (status_r[`SFR_BIT_MSB]),
		.res_out      (alu_res),
		.zero_out     (alu_zero),
		.nib_out      (alu_nib),
		.msb_out      (alu_msb),
		.upd_zero_out (upd_zero),
		.upd_nib_out  (upd_nib),
		.upd_msb_out  (upd_msb)
	);

	assign data_wr  = exec_in && dest_status_in;
	assign flag_blk = upd_zero || upd_nib || upd_msb;
	// guard forces reserved bits low
	assign rsvd_nxt = ctrl_guard_r ? 2'b00 : alu_res[7:6];

	// ****************************************
	// bank and reserved bits
	// ****************************************
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			status_r[7:5] <= `SFR_RST_UPPER;
		end
		else if (data_wr)
		begin
			status_r[7:6] <= rsvd_nxt;
			status_r[5]   <= alu_res[5];
		end
	end

	// ****************************************
	// time-out bit
	// ****************************************
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			status_r[4] <= `SFR_RST_EVT;
		end
		else if (wdog_expire_in)
		begin
			status_r[4] <= 1'b0;
		end
		else if (wdog_kick_in || sleep_in)
		begin
			status_r[4] <= 1'b1;
		end
	end

	// ****************************************
	// power-down bit
	// ****************************************
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			status_r[3] <= `SFR_RST_EVT;
		end
		else if (sleep_in)
		begin
			status_r[3] <= 1'b0;
		end
		else if (wdog_kick_in)
		begin
			status_r[3] <= 1'b1;
		end
	end

	// ****************************************
	// arithmetic flags
	// ****************************************
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			status_r[2:0] <= `SFR_RST_FLAG;
		end
		else if (exec_in)
		begin
			if (upd_zero)
			begin
				status_r[2] <= alu_zero;
			end
			else if (data_wr && !flag_blk)
			begin
				status_r[2] <= alu_res[2];
			end
			if (upd_nib)
			begin
				status_r[1] <= alu_nib;
			end
			else if (data_wr && !flag_blk)
			begin
				status_r[1] <= alu_res[1];
			end
			if (upd_msb)
			begin
				status_r[0] <= alu_msb;
			end
			else if (data_wr && !flag_blk)
			begin
				status_r[0] <= alu_res[0];
			end
		end
	end

	// ****************************************
	// result and direct address
	// ****************************************
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			result_r <= 8'h00;
		end
		else if (exec_in)
		begin
			result_r <= alu_res;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			bank_addr_r <= 8'h00;
		end
		else
		begin
			bank_addr_r <= {status_r[`SFR_BIT_BANKL], dir_addr_in};
		end
	end

	// ****************************************
	// interrupt events
	// ****************************************
	always_comb
	begin
		ev                = 4'h0;
		ev[`SFR_EV_EXPIRE] = wdog_expire_in;
		ev[`SFR_EV_SLEEP]  = sleep_in;
		ev[`SFR_EV_KICK]   = wdog_kick_in;
		ev[`SFR_EV_RSVD]   = data_wr && (alu_res[7:6] != 2'b00);
	end

	// set wins over write-one-to-clear
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			irq_stat_r <= `SFR_RST_IRQ;
		end
		else if (dp_wr_r && dp_addr_r == `SFR_OFF_IRQ_STAT)
		begin
			irq_stat_r <= (irq_stat_r & ~hwdata_in[3:0]) | ev;
		end
		else
		begin
			irq_stat_r <= irq_stat_r | ev;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			irq_mask_r   <= `SFR_RST_IRQ;
			ctrl_guard_r <= `SFR_RST_CTRL;
		end
		else if (dp_wr_r)
		begin
			if (dp_addr_r == `SFR_OFF_IRQ_MASK)
			begin
				irq_mask_r <= hwdata_in[3:0];
			end
			if (dp_addr_r == `SFR_OFF_CTRL)
			begin
				ctrl_guard_r <= hwdata_in[0];
			end
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			irq_r <= 1'b0;
		end
		else
		begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ****************************************
	// ahb-lite slave, zero wait states
	// ****************************************
	assign ap_take = hsel_in && hready_in && htrans_in[1] && (hsize_in == 3'h2);

	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 8'h00;
			hrdata_r  <= 32'h0000_0000;
		end
		else
		begin
			dp_wr_r <= ap_take && hwrite_in && (haddr_in[31:8] == 24'h00_0000);
			if (ap_take)
			begin
				dp_addr_r <= haddr_in[7:0];
			end
			if (ap_take && !hwrite_in && haddr_in[31:8] == 24'h00_0000)
			begin
				case (haddr_in[7:0])
					`SFR_OFF_STATUS:   hrdata_r <= {24'h00_0000, status_r};
					`SFR_OFF_IRQ_STAT: hrdata_r <= {28'h000_0000, irq_stat_r};
					`SFR_OFF_IRQ_MASK: hrdata_r <= {28'h000_0000, irq_mask_r};
					`SFR_OFF_CTRL:     hrdata_r <= {31'h0000_0000, ctrl_guard_r};
					default:           hrdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign status_out    = status_r;
	assign bank_sel_out  = status_r[`SFR_BIT_BANKL];
	assign bank_addr_out = bank_addr_r;
	assign result_out    = result_r;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign hrdata_out    = hrdata_r;
	assign irq_out       = irq_r;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	property p_bank_map;
		!srst_in |=> bank_addr_out == {$past(status_r[5]), $past(dir_addr_in)};
	endproperty
	a_bank_map: assert property (p_bank_map) else $error("bank address wrong");

	property p_expire;
		wdog_expire_in |=> !status_out[4];
	endproperty
	a_expire: assert property (p_expire) else $error("time-out bit not cleared");

	property p_kick_to;
		(wdog_kick_in || sleep_in) && !wdog_expire_in |=> status_out[4];
	endproperty
	a_kick_to: assert property (p_kick_to) else $error("time-out bit not set");

	property p_sleep_pd;
		sleep_in |=> !status_out[3];
	endproperty
	a_sleep_pd: assert property (p_sleep_pd) else $error("power-down bit not cleared");

	property p_kick_pd;
		wdog_kick_in && !sleep_in |=> status_out[3];
	endproperty
	a_kick_pd: assert property (p_kick_pd) else $error("power-down bit not set");

	property p_zero;
		exec_in && upd_zero |=> status_out[2] == (result_out == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_nib_add;
		exec_in && op_in == sfr_op_add
		|=> status_out[1] == (({1'b0, $past(f_in[3:0])} + {1'b0, $past(w_in[3:0])}) > 5'h0f);
	endproperty
	a_nib_add: assert property (p_nib_add) else $error("nibble carry wrong");

	property p_msb_add;
		exec_in && op_in == sfr_op_add
		|=> status_out[0] == (({1'b0, $past(f_in)} + {1'b0, $past(w_in)}) > 9'h0ff);
	endproperty
	a_msb_add: assert property (p_msb_add) else $error("carry wrong");

	property p_borrow;
		exec_in && op_in == sfr_op_sub |=> status_out[0] == ($past(f_in) >= $past(w_in));
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

	property p_rrc;
		exec_in && op_in == sfr_op_rrc
		|=> status_out[0] == $past(f_in[0]) && result_out[7] == $past(status_r[0]);
	endproperty
	a_rrc: assert property (p_rrc) else $error("rotate carry wrong");

	property p_reset;
		disable iff (1'b0) srst_in |=> status_out[5:3] == 3'b011;
	endproperty
	a_reset: assert property (p_reset) else $error("reset value wrong");

	property p_clr_dest;
		exec_in && dest_status_in && op_in == sfr_op_clr
		|=> status_out[2] && status_out[1:0] == $past(status_r[1:0]);
	endproperty
	a_clr_dest: assert property (p_clr_dest) else $error("flag write not blocked");

	property p_ro_bits;
		data_wr && !wdog_kick_in && !sleep_in && !wdog_expire_in
		|=> status_out[4:3] == $past(status_r[4:3]);
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("read-only bits written");

	property p_commit;
		exec_in && upd_msb |=> status_out[0] == $past(alu_msb) && result_out == $past(alu_res);
	endproperty
	a_commit: assert property (p_commit) else $error("flags and result not committed");

	property p_cov_sub;
		exec_in && op_in == sfr_op_sub;
	endproperty
	c_cov_sub: cover property (p_cov_sub);

	property p_cov_sleep_kick;
		sleep_in ##[1:20] wdog_kick_in;
	endproperty
	c_cov_sleep_kick: cover property (p_cov_sleep_kick);

	property p_cov_irq;
		!irq_out ##1 irq_out;
	endproperty
	c_cov_irq: cover property (p_cov_irq);

endmodule // sfr_status

// ---- design/sfr_defines.svh ----
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// ****************************************
// status bit positions
// ****************************************
`define SFR_BIT_UPPER 7
`define SFR_BIT_BANKH 6
`define SFR_BIT_BANKL 5
`define SFR_BIT_WDOG  4
`define SFR_BIT_SLEEP 3
`define SFR_BIT_ZERO  2
`define SFR_BIT_NIB   1
`define SFR_BIT_MSB   0

// ****************************************
// reset values
// ****************************************
`define SFR_RST_UPPER 3'h0
`define SFR_RST_EVT   1'b1
`define SFR_RST_FLAG  3'h0
`define SFR_RST_IRQ   4'h0
`define SFR_RST_CTRL  1'b0

// ****************************************
// register offsets
// ****************************************
`define SFR_OFF_STATUS   8'h00
`define SFR_OFF_IRQ_STAT 8'h04
`define SFR_OFF_IRQ_MASK 8'h08
`define SFR_OFF_CTRL     8'h0c

// ****************************************
// interrupt event positions
// ****************************************
`define SFR_EV_EXPIRE 0
`define SFR_EV_SLEEP  1
`define SFR_EV_KICK   2
`define SFR_EV_RSVD   3

`endif

// ---- design/sfr_pkg.sv ----
package sfr_pkg;

	// ****************************************
	// core operations
	// ****************************************
	typedef enum logic [3:0]
	{
		sfr_op_none,
		sfr_op_add,
		sfr_op_sub,
		sfr_op_and,
		sfr_op_or,
		sfr_op_xor,
		sfr_op_clr,
		sfr_op_movz,
		sfr_op_inc,
		sfr_op_dec,
		sfr_op_com,
		sfr_op_rrc,
		sfr_op_rlc,
		sfr_op_swap,
		sfr_op_pass
	} sfr_op_type;

endpackage

// ---- design/sfr_alu.sv ----
module sfr_alu
(
	// operation
	input  wire sfr_pkg::sfr_op_type op_in,
	input  wire logic [7:0]          w_in,
	input  wire logic [7:0]          f_in,
	input  wire logic                carry_in,
	// result and flags
	output logic [7:0]               res_out,
	output logic                     zero_out,
	output logic                     nib_out,
	output logic                     msb_out,
	output logic                     upd_zero_out,
	output logic                     upd_nib_out,
	output logic                     upd_msb_out
);
	import sfr_pkg::*;

	logic [7:0] addend;
	logic       cin;
	logic [4:0] nib_sum;
	logic [8:0] sum;

	// subtract as add of two's complement
	always_comb
	begin
		addend  = (op_in == sfr_op_sub) ? ~w_in : w_in;
		cin     = (op_in == sfr_op_sub);
		nib_sum = {1'b0, f_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		sum     = {1'b0, f_in} + {1'b0, addend} + {8'h00, cin};
	end

	always_comb
	begin
		res_out      = f_in;
		nib_out      = 1'b0;
		msb_out      = 1'b0;
		upd_zero_out = 1'b1;
		upd_nib_out  = 1'b0;
		upd_msb_out  = 1'b0;
		case (op_in)
			sfr_op_add, sfr_op_sub:
			begin
				res_out     = sum[7:0];
				nib_out     = nib_sum[4];
				msb_out     = sum[8];
				upd_nib_out = 1'b1;
				upd_msb_out = 1'b1;
			end
			sfr_op_and:  res_out = f_in & w_in;
			sfr_op_or:   res_out = f_in | w_in;
			sfr_op_xor:  res_out = f_in ^ w_in;
			sfr_op_clr:  res_out = 8'h00;
			sfr_op_movz: res_out = f_in;
			sfr_op_inc:  res_out = f_in + 8'h01;
			sfr_op_dec:  res_out = f_in - 8'h01;
			sfr_op_com:  res_out = ~f_in;
			sfr_op_rrc:
			begin
				res_out      = {carry_in, f_in[7:1]};
				msb_out      = f_in[0];
				upd_zero_out = 1'b0;
				upd_msb_out  = 1'b1;
			end
			sfr_op_rlc:
			begin
				res_out      = {f_in[6:0], carry_in};
				msb_out      = f_in[7];
				upd_zero_out = 1'b0;
				upd_msb_out  = 1'b1;
			end
			sfr_op_swap:
			begin
				res_out      = {f_in[3:0], f_in[7:4]};
				upd_zero_out = 1'b0;
			end
			default:
			begin
				res_out      = f_in;
				upd_zero_out = 1'b0;
			end
		endcase
		zero_out = (res_out == 8'h00);
	end

endmodule // sfr_alu

// ---- dv/sfr_core_model.sv ----
module sfr_core_model
(
	// clock
	input  wire logic           clk_sys_in,
	// instruction commit
	output logic                exec_out,
	output sfr_pkg::sfr_op_type op_out,
	output logic [7:0]          w_out,
	output logic [7:0]          f_out,
	output logic                dest_out,
	// events and addressing
	output logic                kick_out,
	output logic                sleep_out,
	output logic                expire_out,
	output logic [6:0]          dir_out,
	// result visible
	output logic                chk_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_pkg::*;

	initial
	begin
		exec_out = 1'b0;
		op_out = sfr_op_none;
		w_out = 8'h00;
		f_out = 8'h00;
		dest_out = 1'b0;
		{expire_out, sleep_out, kick_out} = 3'h0;
		dir_out = 7'h15;
	end

	// result of a commit or event shows one edge later
	always @(posedge clk_sys_in)
		chk_out <= exec_out | kick_out | sleep_out | expire_out;

	task automatic commit(input sfr_op_type op, input logic [7:0] w, input logic [7:0] f, input logic d);
		@(posedge clk_sys_in);
		exec_out <= 1'b1;
		op_out <= op;
		w_out <= w;
		f_out <= f;
		dest_out <= d;
		{expire_out, sleep_out, kick_out} <= 3'h0;
	endtask

	// released operands never keep their last value
	task automatic ev(input logic [2:0] v);
		@(posedge clk_sys_in);
		exec_out <= 1'b0;
		dest_out <= 1'b0;
		w_out <= ~w_out;
		f_out <= ~f_out;
		{expire_out, sleep_out, kick_out} <= v;
	endtask

	task automatic idle;
		ev(3'h0);
	endtask
endmodule // sfr_core_model

// ---- dv/test_status_flags_register.sv ----
module test_status_flags_register;
	timeunit 1ns;
	timeprecision 1ps;
	import sfr_pkg::*;

	`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
		$display("[ERR] %s exp %h got %h", nm, e, a); end end

	typedef struct {logic [1:0] k; logic [15:0] e; logic [15:0] m; string nm;} sfr_note_type;
	typedef struct {sfr_op_type op; logic [7:0] w; logic [7:0] f; logic [15:0] e; logic [15:0] m;} sfr_vec_type;

	logic        clk_sys_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        exec, dest, kick, slp, expire, chk, bank_sel, hreadyout, hresp, irq;
	sfr_op_type  op;
	logic [7:0]  w, f, bank_addr, result, status, r;
	logic [31:0] rv;
	logic [6:0]  dir;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hrdata;
	logic        look = 1'b0;
	int          n_fail = 0;
	int          tests_run = 0;
	integer      seed = 32'hd1bc6d6c;
	sfr_note_type q[$];
	sfr_op_type  lop[3] = '{sfr_op_and, sfr_op_or, sfr_op_xor};
	sfr_vec_type tv[15] = '{
		'{sfr_op_none, 8'h00, 8'h00, 16'h0018, 16'h00ff},
		'{sfr_op_add,  8'h08, 8'h08, 16'h101a, 16'hffff},
		'{sfr_op_add,  8'h01, 8'hff, 16'h001f, 16'hffff},
		'{sfr_op_sub,  8'h03, 8'h05, 16'h021b, 16'hffff},
		'{sfr_op_sub,  8'h05, 8'h03, 16'hfe18, 16'hffff},
		'{sfr_op_rrc,  8'h00, 8'h01, 16'h0019, 16'hffff},
		'{sfr_op_rlc,  8'h00, 8'h7f, 16'hff18, 16'hffff},
		'{sfr_op_rlc,  8'h00, 8'h80, 16'h0019, 16'hffff},
		'{sfr_op_sub,  8'h01, 8'h10, 16'h0f19, 16'hffff},
		'{sfr_op_xor,  8'h5a, 8'h5a, 16'h001d, 16'hffff},
		'{sfr_op_inc,  8'h00, 8'h0f, 16'h1019, 16'hffff},
		'{sfr_op_dec,  8'h00, 8'h01, 16'h001d, 16'hffff},
		'{sfr_op_com,  8'h00, 8'h0f, 16'hf019, 16'hffff},
		'{sfr_op_swap, 8'h00, 8'h00, 16'h0019, 16'hffff},
		'{sfr_op_movz, 8'h00, 8'h00, 16'h001d, 16'hffff}};
	logic [2:0]  evv[4] = '{3'h1, 3'h4, 3'h2, 3'h5};
	logic [7:0]  evs[4] = '{8'h1f, 8'h0f, 8'h17, 8'h0f};

	always #2.5 clk_sys_in = ~clk_sys_in;

	sfr_core_model sfr_core_model_inst (.clk_sys_in(clk_sys_in), .exec_out(exec), .op_out(op), .w_out(w),
		.f_out(f), .dest_out(dest), .kick_out(kick), .sleep_out(slp), .expire_out(expire), .dir_out(dir),
		.chk_out(chk));

	sfr_status sfr_status_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .exec_in(exec), .op_in(op),
		.w_in(w), .f_in(f), .dest_status_in(dest), .wdog_kick_in(kick), .sleep_in(slp),
		.wdog_expire_in(expire), .dir_addr_in(dir), .bank_addr_out(bank_addr), .bank_sel_out(bank_sel),
		.result_out(result), .status_out(status), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
		.hreadyout_out(hreadyout), .hrdata_out(hrdata), .hresp_out(hresp), .irq_out(irq));

	task automatic note(input logic [1:0] k, input logic [15:0] e, input logic [15:0] m, input string nm);
		q.push_back('{k, e, m, nm});
	endtask

	task automatic wrap_up;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wait_rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge clk_sys_in);
			i++;
		end
		while (hreadyout !== 1'b1 && i < 16);
		if (i >= 16)
		begin
			n_fail++;
			$display("[ERR] hready exp 1 got stuck");
			wrap_up();
		end
	endtask

	// single word transfer, read data judged by the monitor in the data phase
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [15:0] e);
		@(posedge clk_sys_in);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		look <= !wr;
		if (!wr)
			note(1, e, 16'hffff, "hrdata");
		wait_rdy();
		look <= 1'b0;
	endtask

	task automatic probe(input logic [15:0] e);
		@(posedge clk_sys_in);
		look <= 1'b1;
		note(2, e, 16'h07ff, "irq_bank");
		@(posedge clk_sys_in);
		look <= 1'b0;
	endtask

	// ****************************************
	// monitor
	// ****************************************
	always @(negedge clk_sys_in)
	begin
		sfr_note_type n;
		logic [15:0]  a;
		if (chk === 1'b1 || look === 1'b1)
		begin
			if (q.size() == 0)
			begin
				n_fail++;
				$display("[ERR] note exp queued got none");
			end
			else
			begin
				n = q.pop_front();
				a = (n.k == 0) ? {result, status} : (n.k == 1) ? hrdata[15:0] :
					{5'h00, hresp, bank_sel, irq, bank_addr};
				`CHK(n.nm, n.e & n.m, a & n.m)
			end
		end
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		$display("[ERR] run exp done got hang");
		wrap_up();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		foreach (tv[i])
		begin
			sfr_core_model_inst.commit(tv[i].op, tv[i].w, tv[i].f, 1'b0);
			note(0, tv[i].e, tv[i].m, "core");
		end
		repeat (12)
		begin
			rv = $random(seed);
			r = (rv[1:0] % 3 == 0) ? (rv[15:8] & rv[23:16]) : (rv[1:0] % 3 == 1) ? (rv[15:8] | rv[23:16]) :
				(rv[15:8] ^ rv[23:16]);
			sfr_core_model_inst.commit(lop[rv[1:0] % 3], rv[23:16], rv[15:8], 1'b0);
			note(0, {r, 5'h00, r == 8'h00, 2'b00}, 16'hff04, "logic");
		end
		sfr_core_model_inst.idle();
		$display("test flags done");
		sfr_core_model_inst.ev(3'h2);
		note(0, 16'h0010, 16'h0018, "core");
		sfr_core_model_inst.commit(sfr_op_pass, 8'h00, 8'hff, 1'b1);
		note(0, 16'h00f7, 16'h00ff, "core");
		sfr_core_model_inst.idle();
		probe(16'h0295);
		sfr_core_model_inst.commit(sfr_op_clr, 8'h00, 8'h00, 1'b1);
		note(0, 16'h0017, 16'hffff, "core");
		foreach (evv[i])
		begin
			sfr_core_model_inst.ev(evv[i]);
			note(0, {8'h00, evs[i]}, 16'h00ff, "core");
		end
		sfr_core_model_inst.idle();
		$display("test events done");
		ahb(0, 32'h04, 0, 16'h000f);
		ahb(0, 32'h00, 0, 16'h000f);
		probe(16'h0015);
		ahb(1, 32'h08, 32'h2, 0);
		probe(16'h0115);
		ahb(1, 32'h04, 32'h2, 0);
		probe(16'h0015);
		ahb(0, 32'h04, 0, 16'h000d);
		ahb(0, 32'h10, 0, 16'h0000);
		ahb(1, 32'h00, 32'h0, 0);
		ahb(0, 32'h00, 0, 16'h000f);
		ahb(1, 32'h0c, 32'h1, 0);
		sfr_core_model_inst.commit(sfr_op_pass, 8'h00, 8'hff, 1'b1);
		note(0, 16'h002f, 16'h00ff, "core");
		sfr_core_model_inst.idle();
		repeat (3) @(posedge clk_sys_in);
		$display("test bus done");
		`CHK("queue", 0, q.size())
		wrap_up();
	end
endmodule // test_status_flags_register
